// ### verilog/tesp_regs.vh
// register offsets, field positions and reset values for the tx-enable / sleep pin block
// assumes a 15-bit serial register address and byte-wide registers
`ifndef TESP_REGS_VH
`define TESP_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TESP_ADDR_MAKER_LO 15'h000C
`define TESP_ADDR_MAKER_HI 15'h000D
`define TESP_ADDR_SLEEP_CFG 15'h0020
`define TESP_ADDR_SRC_SEL 15'h0021
`define TESP_ADDR_TX_BITS 15'h0022
`define TESP_ADDR_PIN_STATE 15'h003C

// ----------------------------------------------------------------
// reset values and fixed codes
// ----------------------------------------------------------------
`define TESP_RST_SLEEP_CFG 8'h00
`define TESP_RST_SRC_SEL 8'h0F
`define TESP_RST_TX_BITS 8'h00
// maker code value is arbitrary
`define TESP_MAKER_CODE 16'h5A3C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TESP_BIT_SLEEP_FULL 0
`define TESP_BIT_SRC_A 0
`define TESP_BIT_SRC_B 1
`define TESP_BIT_SILENCE_A 2
`define TESP_BIT_SILENCE_B 3
`define TESP_BIT_TX_A 0
`define TESP_BIT_TX_B 1
`define TESP_BIT_PS_SLEEP 7
`define TESP_BIT_PS_SYNC 6
`define TESP_BIT_PS_TXPIN 5
`define TESP_BIT_PS_BANK 4
`define TESP_BIT_PS_SEL_HI 3

// ----------------------------------------------------------------
// power modes and serial frame
// ----------------------------------------------------------------
`define TESP_MODE_SLEEP 2'h2
`define TESP_MODE_OFF 2'h3
`define TESP_HDR_LAST 5'h0F
`define TESP_FRAME_LAST 5'h17
`define TESP_FRAME_WRAP 5'h10

`endif

// ### verilog/tesp_pin_ctrl.v
// tx-enable, automute and sleep pin control registers behind a serial register port
// assumes all pins, the serial clock and the trigger clock are synchronous to mclk
// Functional notes
// - sleep pin gives mode 2, or 3 if configured
// - sleep pin never alters stored power mode field
// - channel b muted by alarm when silence bit set
// - channel a muted by alarm when silence bit set
// - source bit b 0: follow transmit-enable pin
// - source bit b 1: follow register bit only
// - source bit a 0: follow transmit-enable pin
// - source bit a 1: follow register bit only
// - register bit 1 enables channel b transmitter
// - register bit 0 enables channel a transmitter
// - pin state bit 7 reads sleep input
// - pin state bit 6 reads sync input
// - pin state bit 5 reads transmit-enable input
// - bit 4 holds bank select at trigger edge
// - bits 3-0 hold select at trigger edge
// - sixteen-bit read-only maker identity register
// - mode 2 is sleep, mode 3 full off
`include "tesp_regs.vh"
`default_nettype none

module tesp_pin_ctrl (
  // clock and reset
  input wire mclk,
  input wire rst,
  // serial register port
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg spi_sdo_oe,
  // device pins
  input wire sleep_in,
  input wire sync_n_in,
  input wire txenable_in,
  input wire trig_c,
  input wire nco_banksel_in,
  input wire [3:0] nco_sel_in,
  // alarms with clear mute mask, per channel
  input wire alarm_chan_a,
  input wire alarm_chan_b,
  // stored power mode field from the device configuration register
  input wire [1:0] cfg_power_mode,
  // effective controls
  output reg [1:0] eff_power_mode,
  output reg transmit_chan_a,
  output reg transmit_chan_b,
  output reg mute_chan_a,
  output reg mute_chan_b
);

  // ----------------------------------------------------------------
  // stored registers
  // ----------------------------------------------------------------
  reg [7:0] sleep_cfg_r;
  reg [7:0] src_sel_r;
  reg [7:0] tx_bits_r;
  reg nco_bank_r;
  reg [3:0] nco_sel_r;
  reg trig_q_r;

  // ----------------------------------------------------------------
  // serial port state
  // ----------------------------------------------------------------
  reg sclk_q_r;
  reg [4:0] bit_cnt_r;
  reg [14:0] addr_r;
  reg rd_r;
  reg [14:0] in_sh_r;
  reg [7:0] out_sh_r;
  reg hdr_rd_r;
  reg [2:0] phase_r;

  // frame phases, one-hot
  localparam PH_IDLE = 3'b001;
  localparam PH_HDR = 3'b010;
  localparam PH_DATA = 3'b100;

  // bit indices of the one-hot register select
  localparam RS_SLEEP = 0;
  localparam RS_SRC = 1;
  localparam RS_TX = 2;
  localparam RS_PIN = 3;
  localparam RS_MAKER_LO = 4;
  localparam RS_MAKER_HI = 5;

  wire sclk_rise = spi_sclk & ~sclk_q_r;
  wire sclk_fall = ~spi_sclk & sclk_q_r;
  wire trig_rise = trig_c & ~trig_q_r;
  wire [7:0] in_byte = {in_sh_r[6:0], spi_sdi};
  // full 15-bit shift so high address bits cannot alias onto the map
  wire [14:0] hdr_addr = {in_sh_r[13:0], spi_sdi};
  wire [15:0] addr_sum = {1'b0, addr_r} + 16'h0001;
  // streaming past the top of the space wraps to zero
  wire [14:0] next_addr = addr_sum[14:0];
  wire [15:0] maker_code = `TESP_MAKER_CODE;
  wire [7:0] pin_state;
  wire in_data = (phase_r == PH_DATA);

  // ----------------------------------------------------------------
  // pin state image
  // ----------------------------------------------------------------
  // pin levels in bits 7-5 are live; a read shows them as of the byte load, not of each bit
  assign pin_state[`TESP_BIT_PS_SLEEP] = sleep_in;
  assign pin_state[`TESP_BIT_PS_SYNC] = sync_n_in;
  assign pin_state[`TESP_BIT_PS_TXPIN] = txenable_in;
  assign pin_state[`TESP_BIT_PS_BANK] = nco_bank_r;
  assign pin_state[`TESP_BIT_PS_SEL_HI:0] = nco_sel_r;

  // ----------------------------------------------------------------
  // address decode, shared by read mux and write path
  // ----------------------------------------------------------------
  function [5:0] fn_reg_sel;
    input [14:0] a;
    begin
      fn_reg_sel = 6'h00;
      if (a == `TESP_ADDR_SLEEP_CFG) begin
        fn_reg_sel[RS_SLEEP] = 1'b1;
      end else if (a == `TESP_ADDR_SRC_SEL) begin
        fn_reg_sel[RS_SRC] = 1'b1;
      end else if (a == `TESP_ADDR_TX_BITS) begin
        fn_reg_sel[RS_TX] = 1'b1;
      end else if (a == `TESP_ADDR_PIN_STATE) begin
        fn_reg_sel[RS_PIN] = 1'b1;
      end else if (a == `TESP_ADDR_MAKER_LO) begin
        fn_reg_sel[RS_MAKER_LO] = 1'b1;
      end else if (a == `TESP_ADDR_MAKER_HI) begin
        fn_reg_sel[RS_MAKER_HI] = 1'b1;
      end
    end
  endfunction

  // read mux; unmapped addresses read as zero
  function [7:0] fn_read;
    input [14:0] a;
    reg [5:0] s;
    begin
      s = fn_reg_sel(a);
      if (s[RS_MAKER_LO]) begin
        fn_read = maker_code[7:0];
      end else if (s[RS_MAKER_HI]) begin
        fn_read = maker_code[15:8];
      end else if (s[RS_SLEEP]) begin
        fn_read = sleep_cfg_r;
      end else if (s[RS_SRC]) begin
        fn_read = src_sel_r;
      end else if (s[RS_TX]) begin
        fn_read = tx_bits_r;
      end else if (s[RS_PIN]) begin
        fn_read = pin_state;
      end else begin
        fn_read = 8'h00;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // frame phase
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r <= PH_IDLE;
    end else if (spi_cs_n) begin
      phase_r <= PH_IDLE;
    end else begin
      case (phase_r)
        PH_IDLE: begin
          if (sclk_rise) begin
            phase_r <= PH_HDR;
          end
        end
        PH_HDR: begin
          if (sclk_rise && bit_cnt_r == `TESP_HDR_LAST) begin
            phase_r <= PH_DATA;
          end
        end
        PH_DATA: begin
          phase_r <= PH_DATA;
        end
        default: begin
          phase_r <= PH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame sequencing: 1 rw bit, 15 address bits, then data bytes
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_q_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      addr_r <= 15'h0000;
      rd_r <= 1'b0;
      hdr_rd_r <= 1'b0;
      in_sh_r <= 15'h0000;
      out_sh_r <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      sclk_q_r <= spi_sclk;
      if (spi_cs_n) begin
        // deselect aborts any partial byte
        bit_cnt_r <= 5'h00;
        spi_sdo_oe <= 1'b0;
        spi_sdo <= 1'b0;
      end else begin
        if (sclk_rise) begin
          in_sh_r <= hdr_addr;
          if (bit_cnt_r == 5'h00) begin
            hdr_rd_r <= spi_sdi;
          end
          if (bit_cnt_r == `TESP_HDR_LAST) begin
            addr_r <= hdr_addr;
            rd_r <= hdr_rd_r;
            out_sh_r <= fn_read(hdr_addr);
          end
          if (bit_cnt_r == `TESP_FRAME_LAST) begin
            // streaming: address ascends after every byte
            addr_r <= next_addr;
            out_sh_r <= fn_read(next_addr);
            bit_cnt_r <= `TESP_FRAME_WRAP;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
        end
        if (sclk_fall && in_data && rd_r) begin
          spi_sdo <= out_sh_r[7];
          spi_sdo_oe <= 1'b1;
          out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
      end
    end
  end

  wire wr_strobe = ~spi_cs_n & in_data & sclk_rise & (bit_cnt_r == `TESP_FRAME_LAST) & ~rd_r;
  wire [5:0] wr_sel = fn_reg_sel(addr_r);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_cfg_r <= `TESP_RST_SLEEP_CFG;
      src_sel_r <= `TESP_RST_SRC_SEL;
      tx_bits_r <= `TESP_RST_TX_BITS;
    end else if (wr_strobe) begin
      if (wr_sel[RS_SLEEP]) begin
        sleep_cfg_r <= in_byte;
      end else if (wr_sel[RS_SRC]) begin
        src_sel_r <= in_byte;
      end else if (wr_sel[RS_TX]) begin
        tx_bits_r <= in_byte;
      end
      // identity, pin state and unmapped writes fall through untouched
    end
  end

  // ----------------------------------------------------------------
  // trigger clock capture of nco selects
  // ----------------------------------------------------------------
  // sampled on mclk, so a stopped device clock freezes the capture
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_q_r <= 1'b0;
      nco_bank_r <= 1'b0;
      nco_sel_r <= 4'h0;
    end else begin
      trig_q_r <= trig_c;
      if (trig_rise) begin
        nco_bank_r <= nco_banksel_in;
        nco_sel_r <= nco_sel_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // effective controls
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      eff_power_mode <= 2'h0;
      transmit_chan_a <= 1'b0;
      transmit_chan_b <= 1'b0;
      mute_chan_a <= 1'b0;
      mute_chan_b <= 1'b0;
    end else begin
      // pin overrides the mode only here; the stored field is an input and stays as is
      if (sleep_in) begin
        eff_power_mode <= sleep_cfg_r[`TESP_BIT_SLEEP_FULL] ?
                          `TESP_MODE_OFF : `TESP_MODE_SLEEP;
      end else begin
        eff_power_mode <= cfg_power_mode;
      end
      if (src_sel_r[`TESP_BIT_SRC_A]) begin
        transmit_chan_a <= tx_bits_r[`TESP_BIT_TX_A];
      end else begin
        transmit_chan_a <= txenable_in;
      end
      if (src_sel_r[`TESP_BIT_SRC_B]) begin
        transmit_chan_b <= tx_bits_r[`TESP_BIT_TX_B];
      end else begin
        transmit_chan_b <= txenable_in;
      end
      mute_chan_a <= src_sel_r[`TESP_BIT_SILENCE_A] & alarm_chan_a;
      mute_chan_b <= src_sel_r[`TESP_BIT_SILENCE_B] & alarm_chan_b;
    end
  end

endmodule // tesp_pin_ctrl

`default_nettype wire

// ### verilog/dummy_unused_guard.v
`default_nettype none
`default_nettype wire

// ### tb/tesp_pin_ctrl_asserts.sv
// checker on the pin control ports
// assumes the bench holds pins and alarms low through reset
`default_nettype none
module tesp_pin_ctrl_asserts (
  // clock, reset, serial port
  input wire logic mclk, rst, spi_cs_n, spi_sdo_oe,
  // pins and effective controls
  input wire logic sleep_in, txenable_in, alarm_chan_a, alarm_chan_b,
  input wire logic transmit_chan_a, transmit_chan_b, mute_chan_a, mute_chan_b,
  input wire logic [1:0] cfg_power_mode, eff_power_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // no frame and a steady pin: nothing may move the transmit enables
  sequence quiet_s;
    (spi_cs_n && $stable(txenable_in)) [*3];
  endsequence
  a_mute_a_cause: assert property (mute_chan_a |-> $past(alarm_chan_a))
    else $error("mute a without alarm");
  a_mute_b_cause: assert property (mute_chan_b |-> $past(alarm_chan_b))
    else $error("mute b without alarm");
  a_awake_mode: assert property (!$past(sleep_in) |-> eff_power_mode == $past(cfg_power_mode))
    else $error("stored power mode not passed on");
  a_sleep_mode: assert property ($past(sleep_in) |-> eff_power_mode[1])
    else $error("sleep pin gave no low power mode");
  a_tx_a_quiet: assert property (quiet_s |=> $stable(transmit_chan_a))
    else $error("transmit a moved without cause");
  a_tx_b_quiet: assert property (quiet_s |=> $stable(transmit_chan_b))
    else $error("transmit b moved without cause");
  a_oe_in_frame: assert property (spi_sdo_oe |-> !$past(spi_cs_n, 2))
    else $error("read data driven outside a frame");
  a_oe_drop: assert property (spi_cs_n ##1 spi_cs_n |=> !spi_sdo_oe)
    else $error("read data driver left on");
endmodule // tesp_pin_ctrl_asserts
`default_nettype wire

// ### tb/tesp_host_model.sv
// host model: serial register port, mode 0, msb first
// assumes mclk from the bench; all changes at the falling edge
`default_nettype none
module tesp_host_model (
  input wire logic mclk,
  input wire logic spi_sdo,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {spi_sclk, spi_cs_n, spi_sdi} = 3'b010;
  // two mclk per phase so the device sees every sclk edge
  task automatic half;
    repeat (2) @(negedge mclk);
  endtask
  task automatic xfer(input logic rw, input logic [14:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [23:0] w;
    w = {rw, adr, wd};
    rd = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = w[i];
      half();
      spi_sclk = 1'b1;
      if (i < 8) rd = {rd[6:0], spi_sdo};
      half();
      spi_sclk = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi; // released line shows no stale bit
    half();
  endtask
endmodule // tesp_host_model
`default_nettype wire

// ### tb/tb.sv
// bench: integer model of registers and pin logic against the design
// assumes the host model drives the serial port
`include "tesp_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, sclk, cs_n, sdi, sdo, sleep, syncn, tx_pin, trig, bank;
  logic [7:0] exp_q[$];
  logic alm_a, alm_b, tx_a, tx_b, mu_a, mu_b;
  logic [3:0] sel;
  logic [1:0] cfg, eff;
  logic [7:0] seed, rd;
  int fails = 0, checks_done = 0, cyc = 0, src = 15, txb = 0, pcfg = 0;
  tesp_pin_ctrl i_tesp_pin_ctrl (.mclk(mclk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(), .sleep_in(sleep), .sync_n_in(syncn),
    .txenable_in(tx_pin), .trig_c(trig), .nco_banksel_in(bank), .nco_sel_in(sel),
    .alarm_chan_a(alm_a), .alarm_chan_b(alm_b), .cfg_power_mode(cfg), .eff_power_mode(eff),
    .transmit_chan_a(tx_a), .transmit_chan_b(tx_b), .mute_chan_a(mu_a), .mute_chan_b(mu_b));
  tesp_host_model i_tesp_host_model (.mclk(mclk), .spi_sdo(sdo), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_sdi(sdi));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
    i_tesp_host_model.xfer(1'b1, a, 8'h00, rd);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    i_tesp_host_model.xfer(1'b0, a, d, rd);
  endtask
  task automatic pins_chk;
    logic ea, eb;
    repeat (2) @(negedge mclk);
    ea = src[0] ? txb[0] : tx_pin;
    eb = src[1] ? txb[1] : tx_pin;
    chk({tx_b, tx_a}, {6'h00, eb, ea});
    chk({mu_b, mu_a}, 8'((src[3] & alm_b) * 2 + (src[2] & alm_a)));
    chk(eff, 8'(sleep ? 2 + pcfg[0] : cfg));
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    {rst, sleep, syncn, tx_pin, trig, bank, alm_a, alm_b} = 8'h80;
    {sel, cfg, seed} = {6'h00, 8'h41};
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    rdc(`TESP_ADDR_SLEEP_CFG, 8'h00);
    rdc(`TESP_ADDR_SRC_SEL, 8'h0F);
    rdc(`TESP_ADDR_TX_BITS, 8'h00);
    rdc(`TESP_ADDR_PIN_STATE, 8'h00);
    for (int r = 0; r < 2; r++) begin
      wr(`TESP_ADDR_MAKER_LO + 15'(r), seed);
      wr(`TESP_ADDR_PIN_STATE, seed);
      rdc(`TESP_ADDR_MAKER_LO + 15'(r), 8'(`TESP_MAKER_CODE >> (8 * r)));
      rdc(`TESP_ADDR_PIN_STATE, 8'h00);
    end
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      src = {seed[7:4], 4'(k)};
      wr(`TESP_ADDR_SRC_SEL, 8'(src));
      seed = lfsr(seed);
      txb = seed;
      exp_q.push_back(8'(txb));
      wr(`TESP_ADDR_TX_BITS, seed);
      rdc(`TESP_ADDR_TX_BITS, exp_q.pop_front());
      for (int p = 0; p < 2; p++) begin
        {tx_pin, alm_a, alm_b, cfg} = {p[0], seed[7:6], seed[1:0] ^ 2'(k)};
        pins_chk();
      end
    end
    for (int m = 0; m < 5; m++) begin
      pcfg = m;
      wr(`TESP_ADDR_SLEEP_CFG, 8'(m));
      seed = lfsr(seed);
      {sleep, cfg} = {m[1], seed[1:0]};
      pins_chk();
      rdc(`TESP_ADDR_SLEEP_CFG, 8'(m));
    end
    for (int n = 0; n < 3; n++) begin
      seed = lfsr(seed);
      {sleep, syncn, tx_pin, bank, sel, trig} = {seed, 1'b1};
      @(negedge mclk);
      {bank, sel, trig} = {~seed[4:0], 1'b0};
      rdc(`TESP_ADDR_PIN_STATE, seed);
    end
    summarize();
  end
endmodule // tb
bind tesp_pin_ctrl tesp_pin_ctrl_asserts i_tesp_pin_ctrl_asserts (.mclk(mclk), .rst(rst),
  .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe), .sleep_in(sleep_in),
  .txenable_in(txenable_in), .alarm_chan_a(alarm_chan_a), .alarm_chan_b(alarm_chan_b),
  .transmit_chan_a(transmit_chan_a), .transmit_chan_b(transmit_chan_b),
  .mute_chan_a(mute_chan_a), .mute_chan_b(mute_chan_b), .cfg_power_mode(cfg_power_mode),
  .eff_power_mode(eff_power_mode));
`default_nettype wire
